// file: design/pmt_timer.sv
// period match timer: 8-bit count, period compare, prescaler,
// postscaler, latched match flag, APB register access.
// assumes one synchronous clock; apb master keeps its request stable.
//
// Function
// - an 8-bit count register and an 8-bit period register exist
// - count starts at zero, steps once per prescaled instruction tick
// - prescale select 00 divides by 1, 01 by 4, 1x by 16
// - count equal to period gives a match pulse as timer output
// - a match reloads count with zero and steps the postscaler once
// - postscale select 0000 gives 1:1 up to 1111 giving 1:16
// - postscaler reaching its count sets the sticky match flag
// - the flag raises the interrupt only while enabled
// - software reads and writes count and period at any time
// - reset clears count and loads period with all ones
// - count write, control write and reset clear both scalers
// - a control write leaves the count unchanged
// - timer on bit runs the timer when one, stops it when zero
// - the unscaled match pulse is a time base output for pwm
// - the match pulse drives an optional serial shift clock
//
// Added by the designer: the APB interface to the registers and the address map.
module pmt_timer #(
  parameter int INSTR_DIV = pmt_pkg::PMT_INSTR_DIV
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic matchPulse,
  output logic shiftClock
);
  import pmt_pkg::*;

  localparam int DIV_W = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_TC = DIV_W'(INSTR_DIV - 1);

  generate
    if (INSTR_DIV < 1 || INSTR_DIV > 256) begin : g_bad_div
      $error("pmt_timer: INSTR_DIV must lie in 1 to 256");
    end
    if (PMT_PRE_W < 4 || PMT_POST_W < 4) begin : g_bad_scale
      $error("pmt_timer: scaler counters need at least four bits");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // state
  pmt_control_s control_reg;
  logic [PMT_DATA_W-1:0] count_reg;
  logic [PMT_DATA_W-1:0] count_next;
  logic [PMT_DATA_W-1:0] period_reg;
  logic [DIV_W-1:0] instrDiv_reg;
  logic [PMT_PRE_W-1:0] pre_reg;
  logic [PMT_PRE_W-1:0] pre_next;
  logic [PMT_POST_W-1:0] post_reg;
  logic [PMT_POST_W-1:0] post_next;
  logic matchFlag_reg;
  logic matchEnable_reg;
  pmt_bus_e bus_reg;
  pmt_bus_e bus_next;

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic accessEdge = (bus_reg == PMT_BUS_DONE) && psel && penable;
  wire logic wrEdge = accessEdge && pwrite;
  wire logic selControl = (paddr == PMT_OFS_CONTROL);
  wire logic selCount = (paddr == PMT_OFS_COUNT);
  wire logic selPeriod = (paddr == PMT_OFS_PERIOD);
  wire logic selStatus = (paddr == PMT_OFS_IRQ_STATUS);
  wire logic selMask = (paddr == PMT_OFS_IRQ_MASK);
  wire logic selAny = selControl | selCount | selPeriod | selStatus | selMask;
  wire logic wrControl = wrEdge && selControl;
  wire logic wrCount = wrEdge && selCount;
  wire logic wrPeriod = wrEdge && selPeriod;
  wire logic wrStatus = wrEdge && selStatus;
  wire logic wrMask = wrEdge && selMask;

  // read data is captured at the end of the wait state, on the same edge that raises pready
  wire logic [31:0] readMux =
    selControl ? {24'h000000, 1'b0, control_reg} :
    selCount ? {24'h000000, count_reg} :
    selPeriod ? {24'h000000, period_reg} :
    selStatus ? {31'h00000000, matchFlag_reg} :
    selMask ? {31'h00000000, matchEnable_reg} : 32'h00000000;

  // one wait state keeps prdata, pready and pslverr flip-flop driven
  always_comb begin
    case (bus_reg)
      PMT_BUS_IDLE: bus_next = (psel && penable) ? PMT_BUS_WAIT : PMT_BUS_IDLE;
      PMT_BUS_WAIT: bus_next = PMT_BUS_DONE;
      PMT_BUS_DONE: bus_next = PMT_BUS_IDLE;
      default: bus_next = PMT_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      bus_reg <= PMT_BUS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      bus_reg <= bus_next;
      pready <= (bus_next == PMT_BUS_DONE);
      pslverr <= (bus_next == PMT_BUS_DONE) && !selAny;
      if (bus_reg == PMT_BUS_WAIT) begin
        prdata <= pwrite ? 32'h00000000 : readMux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // instruction clock enable: a quarter of the oscillator clock
  wire logic instrTick = (instrDiv_reg == DIV_TC);

  always_ff @(posedge clock) begin
    if (reset) begin
      instrDiv_reg <= '0;
    end else begin
      instrDiv_reg <= instrTick ? '0 : instrDiv_reg + DIV_W'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // prescaler, compare and postscaler
  wire logic [PMT_PRE_W-1:0] preTc =
    (control_reg.prescaleSelect == PMT_PRE_SEL_DIV1) ? PMT_PRE_TC_DIV1 :
    (control_reg.prescaleSelect == PMT_PRE_SEL_DIV4) ? PMT_PRE_TC_DIV4 :
    PMT_PRE_TC_DIV16;
  wire logic runTick = control_reg.timerOn && instrTick;
  wire logic scalerClear = wrCount || wrControl;
  // a count or control write swallows the tick of its cycle; the count holds or takes the written value
  wire logic timerTick = runTick && (pre_reg == preTc) && !scalerClear;
  wire logic isMatch = (count_reg == period_reg);
  wire logic matchEvent = timerTick && isMatch;
  wire logic postDone = (post_reg == control_reg.postscaleSelect);
  wire logic flagSet = matchEvent && postDone && !wrCount && !wrControl;

  always_comb begin
    count_next = count_reg;
    pre_next = pre_reg;
    post_next = post_reg;
    if (wrCount) begin
      count_next = pwdata[PMT_DATA_W-1:0];
    end else if (matchEvent) begin
      count_next = PMT_COUNT_RESET;
    end else if (timerTick) begin
      count_next = count_reg + PMT_DATA_W'(1);
    end
    if (scalerClear) begin
      pre_next = '0;
      post_next = '0;
    end else begin
      if (runTick) begin
        pre_next = (pre_reg == preTc) ? '0 : pre_reg + PMT_PRE_W'(1);
      end
      if (matchEvent) begin
        post_next = postDone ? '0 : post_reg + PMT_POST_W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg <= PMT_COUNT_RESET;
      period_reg <= PMT_PERIOD_RESET;
      pre_reg <= '0;
      post_reg <= '0;
    end else begin
      count_reg <= count_next;
      pre_reg <= pre_next;
      post_reg <= post_next;
      if (wrPeriod) begin
        period_reg <= pwdata[PMT_DATA_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control, flag and mask
  always_ff @(posedge clock) begin
    if (reset) begin
      control_reg <= PMT_CONTROL_RESET;
      matchFlag_reg <= 1'b0;
      matchEnable_reg <= 1'b0;
    end else begin
      if (wrControl) begin
        control_reg <= pwdata[6:0];
      end
      if (wrMask) begin
        matchEnable_reg <= pwdata[PMT_IRQ_MATCH_BIT];
      end
      // a flag-setting match at the postscaler terminal wins over a write-one clear in the same cycle
      if (flagSet) begin
        matchFlag_reg <= 1'b1;
      end else if (wrStatus && pwdata[PMT_IRQ_MATCH_BIT]) begin
        matchFlag_reg <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      irq <= 1'b0;
      matchPulse <= 1'b0;
      shiftClock <= 1'b0;
    end else begin
      irq <= matchFlag_reg && matchEnable_reg;
      matchPulse <= matchEvent;
      // one full shift clock period spans two matches
      if (matchEvent) begin
        shiftClock <= !shiftClock;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_match_reloads_zero: assert property (
    matchEvent && !wrCount |=> count_reg == PMT_COUNT_RESET)
    else $error("count not zero after match");

  a_count_steps_one: assert property (
    timerTick && !isMatch && !wrCount |=> count_reg == $past(count_reg) + 8'h01)
    else $error("count did not step by one");

  a_stopped_holds: assert property (
    !control_reg.timerOn && !wrCount && !wrControl
      |=> $stable(count_reg) && $stable(pre_reg) && $stable(post_reg))
    else $error("stopped timer changed state");

  a_stopped_no_match: assert property (
    !control_reg.timerOn |=> !matchPulse)
    else $error("match pulse while stopped");

  a_control_keeps_count: assert property (
    wrControl |=> count_reg == $past(count_reg))
    else $error("control write changed count");

  a_write_clears_scale: assert property (
    wrCount || wrControl |=> pre_reg == '0 && post_reg == '0)
    else $error("scalers not cleared by write");

  a_flag_needs_post: assert property (
    !matchFlag_reg ##1 matchFlag_reg |-> $past(matchEvent && postDone))
    else $error("flag set without postscaler terminal");

  a_flag_sticky: assert property (
    matchFlag_reg && !wrStatus |=> matchFlag_reg)
    else $error("flag dropped without clear");

  a_irq_gated: assert property (
    ##1 irq == $past(matchFlag_reg && matchEnable_reg))
    else $error("interrupt not equal to enabled flag");

  a_pulse_follows_match: assert property (
    matchEvent |=> matchPulse ##1 !matchPulse || $past(matchEvent))
    else $error("match pulse missing");

  a_presc_div4: assert property (
    control_reg.prescaleSelect == PMT_PRE_SEL_DIV4 && timerTick
      ##1 !wrControl && !wrCount |-> pre_reg == '0)
    else $error("prescaler did not restart");

  a_period_reset: assert property (
    $fell(reset) |-> period_reg == PMT_PERIOD_RESET && count_reg == '0)
    else $error("reset values wrong");

  // register access
  a_count_write: assert property (
    wrCount |=> count_reg == $past(pwdata[PMT_DATA_W-1:0]))
    else $error("count write did not land");

  a_period_write: assert property (
    wrPeriod |=> period_reg == $past(pwdata[PMT_DATA_W-1:0]))
    else $error("period write did not land");

  a_period_holds: assert property (
    !wrPeriod |=> $stable(period_reg))
    else $error("period changed without a write");

  a_ready_single: assert property (
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  a_unmapped_error: assert property (
    pready |-> pslverr == $past(!selAny))
    else $error("error response does not match the address");

  // scalers and count
  a_presc_steps: assert property (
    runTick && !scalerClear && !timerTick
      |=> pre_reg == $past(pre_reg) + PMT_PRE_W'(1))
    else $error("prescaler did not step");

  a_presc_div1: assert property (
    control_reg.prescaleSelect == PMT_PRE_SEL_DIV1 && runTick && !scalerClear
      |-> timerTick)
    else $error("undivided prescaler dropped a tick");

  a_presc_div16: assert property (
    control_reg.prescaleSelect[1] && timerTick
      |-> pre_reg == PMT_PRE_TC_DIV16)
    else $error("divide by sixteen ended early");

  a_post_steps: assert property (
    matchEvent && !postDone |=> post_reg == $past(post_reg) + PMT_POST_W'(1))
    else $error("postscaler did not step on match");

  a_post_wraps: assert property (
    matchEvent && postDone |=> post_reg == '0)
    else $error("postscaler did not wrap");

  a_post_idle: assert property (
    !matchEvent && !scalerClear |=> $stable(post_reg))
    else $error("postscaler moved without a match");

  a_count_idle: assert property (
    !timerTick && !wrCount |=> $stable(count_reg))
    else $error("count moved without a tick");

  a_reset_scalers: assert property (
    $fell(reset) |-> pre_reg == '0 && post_reg == '0)
    else $error("scalers not cleared by reset");

  // flag, interrupt and outputs
  a_set_wins: assert property (
    flagSet |=> matchFlag_reg)
    else $error("flag not set on postscaler terminal");

  a_flag_clears: assert property (
    wrStatus && pwdata[PMT_IRQ_MATCH_BIT] && !flagSet |=> !matchFlag_reg)
    else $error("write one did not clear the flag");

  a_flag_stays_clear: assert property (
    !matchFlag_reg && !flagSet |=> !matchFlag_reg)
    else $error("flag set without a postscaler terminal");

  a_irq_masked: assert property (
    !matchEnable_reg |=> !irq)
    else $error("interrupt raised while disabled");

  a_pulse_needs_match: assert property (
    matchPulse |-> $past(matchEvent))
    else $error("match pulse without a match");

  a_pulse_count_zero: assert property (
    matchPulse |-> count_reg == PMT_COUNT_RESET)
    else $error("count not zero with match pulse");

  a_shift_toggles: assert property (
    matchEvent |=> shiftClock != $past(shiftClock))
    else $error("shift clock did not toggle on match");

  a_shift_holds: assert property (
    !matchEvent |=> $stable(shiftClock))
    else $error("shift clock moved without a match");

  c_match_seen: cover property (matchEvent);
  c_flag_set: cover property (!matchFlag_reg ##1 matchFlag_reg);
  c_irq_raised: cover property ($rose(irq));
  c_set_and_clear: cover property (flagSet && wrStatus);
  c_div16_match: cover property (control_reg.prescaleSelect[1] && matchEvent);

endmodule // pmt_timer

// file: pkg/pmt_pkg.sv
// package for the period match timer: register map, field layout,
// reset values and timing constants.
// assumes a 250 MHz oscillator clock and an APB slave with 32-bit data.
package pmt_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] PMT_OFS_CONTROL = 8'h00;
  localparam logic [7:0] PMT_OFS_COUNT = 8'h04;
  localparam logic [7:0] PMT_OFS_PERIOD = 8'h08;
  localparam logic [7:0] PMT_OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] PMT_OFS_IRQ_MASK = 8'h10;

  ////////////////////////////////////////////////////////////////////////
  // widths and reset values
  localparam int PMT_DATA_W = 8;
  localparam int PMT_PRE_W = 4;
  localparam int PMT_POST_W = 4;
  localparam logic [7:0] PMT_COUNT_RESET = 8'h00;
  localparam logic [7:0] PMT_PERIOD_RESET = 8'hFF;
  localparam logic [6:0] PMT_CONTROL_RESET = 7'h00;

  // prescaler terminal counts: divide by 1, 4 and 16
  localparam logic [3:0] PMT_PRE_TC_DIV1 = 4'h0;
  localparam logic [3:0] PMT_PRE_TC_DIV4 = 4'h3;
  localparam logic [3:0] PMT_PRE_TC_DIV16 = 4'hF;
  localparam logic [1:0] PMT_PRE_SEL_DIV1 = 2'h0;
  localparam logic [1:0] PMT_PRE_SEL_DIV4 = 2'h1;

  // interrupt status and mask bit of the match event
  localparam int PMT_IRQ_MATCH_BIT = 0;

  ////////////////////////////////////////////////////////////////////////
  // timing: oscillator period and instruction clock ratio
  localparam int PMT_OSC_PERIOD_NS = 4;
  localparam int PMT_INSTR_PER_OSC = 4;
  localparam int PMT_INSTR_PERIOD_NS = PMT_OSC_PERIOD_NS * PMT_INSTR_PER_OSC;
  localparam int PMT_INSTR_DIV = PMT_INSTR_PERIOD_NS / PMT_OSC_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////
  // control register, bit 7 reads as zero
  typedef struct packed {
    logic [3:0] postscaleSelect;
    logic timerOn;
    logic [1:0] prescaleSelect;
  } pmt_control_s;

  // APB access state of the slave
  typedef enum logic [2:0] {
    PMT_BUS_IDLE = 3'b001,
    PMT_BUS_WAIT = 3'b010,
    PMT_BUS_DONE = 3'b100
  } pmt_bus_e;

endpackage

// file: test/pmt_timer_tb.sv
// self-checking bench for the period match timer, registers over apb.
// assumes the timer is built with an instruction divide of one.
module pmt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmt_pkg::*;
  logic clock, reset, psel, penable, pwrite, pready, pslverr;
  logic irq, matchPulse, shiftClock;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [33:0] notes[$];
  logic [33:0] note;
  int numErrors, testsRun;

  pmt_timer #(.INSTR_DIV(1)) i_dut (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .matchPulse(matchPulse),
    .shiftClock(shiftClock));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic closeOut();
    $display("errors %0d, checks %0d", numErrors, testsRun);
    if (numErrors == 0 && testsRun > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic giveUp();
    numErrors++;
    $display("mismatch at %0t: wait ran out", $time);
    closeOut();
  endtask

  // one transfer; an idle cycle follows so psel is never set twice at once
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] exp, input logic err);
    int n;
    notes.push_back({~wr, err, exp});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!pready && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) giveUp();
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, exp, 1'b0);
  endtask

  task automatic waitPulse(output int n);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!matchPulse && n < 2000);
    if (n >= 2000) giveUp();
  endtask

  // stop, clear flag, zero count, set period, then start
  task automatic cfg(input logic [6:0] ctrl, input logic [7:0] per);
    wr(PMT_OFS_CONTROL, 32'h0);
    wr(PMT_OFS_IRQ_STATUS, 32'h1);
    wr(PMT_OFS_COUNT, 32'h0);
    wr(PMT_OFS_PERIOD, {24'h0, per});
    wr(PMT_OFS_CONTROL, {25'h0, ctrl});
  endtask

  //////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (pready) begin
      if (notes.size() == 0) giveUp();
      else begin
        note = notes.pop_front();
        check({31'h0, pslverr}, {31'h0, note[32]});
        if (note[33]) check(prdata, note[31:0]);
      end
    end
  end

  initial begin
    int n, k;
    logic s;
    logic [7:0] p;
    logic [3:0] post;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    numErrors = 0;
    testsRun = 0;
    void'($urandom(32'hFDA6DBB1));
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(PMT_OFS_CONTROL, 32'h0);
    rd(PMT_OFS_COUNT, 32'h0);
    rd(PMT_OFS_PERIOD, 32'hFF);
    rd(PMT_OFS_IRQ_STATUS, 32'h0);
    rd(PMT_OFS_IRQ_MASK, 32'h0);
    apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h14, 32'h1, 32'h0, 1'b1);
    wr(PMT_OFS_CONTROL, 32'h80);
    rd(PMT_OFS_CONTROL, 32'h0);
    // stopped timer sitting on its period must not match
    p = 8'($urandom_range(2, 250));
    wr(PMT_OFS_PERIOD, {24'h0, p});
    rd(PMT_OFS_PERIOD, {24'h0, p});
    wr(PMT_OFS_COUNT, {24'h0, p});
    wr(PMT_OFS_CONTROL, 32'h28);
    rd(PMT_OFS_COUNT, {24'h0, p});
    k = 0;
    repeat (40) begin
      @(posedge clock);
      if (matchPulse) k++;
    end
    check(k, 0);
    rd(PMT_OFS_COUNT, {24'h0, p});
    for (int sel = 0; sel < 4; sel++) begin
      p = 8'($urandom_range(1, 6));
      cfg({4'h0, 1'b1, 2'(sel)}, p);
      waitPulse(n);
      s = shiftClock;
      waitPulse(n);
      check(n, (p + 1) * (sel == 0 ? 1 : sel == 1 ? 4 : 16));
      check({31'h0, shiftClock}, {31'h0, ~s});
    end
    for (int i = 0; i < 4; i++) begin
      post = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom_range(1, 14));
      wr(PMT_OFS_IRQ_MASK, 32'h1);
      cfg({post, 1'b1, 2'b00}, 8'h02);
      k = 0;
      n = 0;
      do begin
        @(posedge clock);
        n++;
        if (!irq && matchPulse) k++;
      end while (!irq && n < 2000);
      if (n >= 2000) giveUp();
      check(k, post + 1);
    end
    // masked flag stays sticky but no longer drives the interrupt
    wr(PMT_OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    rd(PMT_OFS_IRQ_STATUS, 32'h1);
    wr(PMT_OFS_CONTROL, 32'h0);
    wr(PMT_OFS_IRQ_STATUS, 32'h1);
    rd(PMT_OFS_IRQ_STATUS, 32'h0);
    // reset in mid-run while the timer is counting
    wr(PMT_OFS_PERIOD, 32'h5);
    wr(PMT_OFS_CONTROL, 32'h4);
    repeat (12) @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd(PMT_OFS_COUNT, 32'h0);
    rd(PMT_OFS_PERIOD, 32'hFF);
    rd(PMT_OFS_CONTROL, 32'h0);
    closeOut();
  end
endmodule // pmt_timer_tb
